/* core/mac_frame_mgmt_cfg.sv */
// mac frame options, rx buffer size and station management engine
`timescale 1ns/1ps
module mac_frame_mgmt_cfg (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic frame_idle_i,
	input wire logic len_valid_i,
	input wire logic [15:0] frame_len_i,
	input wire logic [15:0] payload_len_i,
	input wire logic [15:0] len_type_i,
	output mac_cfg_pkg::frame_cfg_t frame_cfg_o,
	output logic [10:0] rx_buf_bytes_o,
	output logic rx_buf_ok_o,
	output logic len_mismatch_o,
	output logic oversize_o,
	output logic mdc_o,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n_o
);
	import mac_cfg_pkg::*;

	logic [31:0] rbc;
	logic [31:0] mfc;
	logic [31:0] smc;
	logic [31:0] cmd;
	logic read_go;
	logic req;
	logic lanes_ok;
	logic wr;
	logic [31:0] lane_mask;
	logic [3:0] blk;
	logic [1:0] op;
	logic [31:0] status;
	logic [31:0] rd_val;
	frame_cfg_t next_cfg;
	logic mreset;
	logic [5:0] half;
	logic [5:0] divcnt;
	logic tick;
	logic fall;
	logic rise;
	logic mdio_s1;
	logic mdio_s2;
	mgmt_state_t mstate;
	logic [5:0] bitcnt;
	logic [15:0] rdata;
	logic [15:0] last_data;
	logic [4:0] last_phy;
	logic [4:0] cur_phy;
	logic pending;
	logic start;
	logic [31:0] frame_bits;
	logic out_bit;
	logic [4:0] target_phy_number;
	logic [4:0] reg_number;

	function automatic logic [31:0] alias_op(input logic [31:0] old,
		input logic [1:0] kind, input logic [31:0] val,
		input logic [31:0] m, input logic [31:0] impl);
		logic [31:0] r;
		r = old;
		case (kind)
			OP_WRITE: r = (old & ~m) | (val & m);
			OP_CLR: r = old & ~(val & m);
			OP_SET: r = old | (val & m);
			OP_INV: r = old ^ (val & m);
			default: r = old;
		endcase
		return r & impl;
	endfunction : alias_op

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign blk = wb_adr_i[7:4];
	assign op = wb_adr_i[3:2];
	// single-byte lanes are dropped whole: no partial store, no read data
	assign lanes_ok = (wb_sel_i == SEL_WORD) | (wb_sel_i == SEL_LOW)
		| (wb_sel_i == SEL_HIGH);
	assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wr = req & wb_we_i & lanes_ok;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_comb begin
		case (blk)
			BLK_RBC: rd_val = rbc;
			BLK_MFC: rd_val = mfc;
			BLK_SMC: rd_val = smc;
			BLK_MGMT: rd_val = (op == MG_CMD) ? cmd :
				(op == MG_STAT) ? status : '0;
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (req)
			wb_dat_o <= lanes_ok ? rd_val : '0;
	end

	// rx buffer size, meant to be rewritten only with the receiver off
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rbc <= RBC_RESET;
		else if (wr && blk == BLK_RBC)
			rbc <= alias_op(rbc, op, wb_dat_i, lane_mask, RBC_MASK);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			mfc <= MFC_RESET;
		else if (wr && blk == BLK_MFC)
			mfc <= alias_op(mfc, op, wb_dat_i, lane_mask, MFC_MASK);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			smc <= SMC_RESET;
		else if (wr && blk == BLK_SMC)
			smc <= alias_op(smc, op, wb_dat_i, lane_mask, SMC_MASK);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cmd <= '0;
		else if (wr && blk == BLK_MGMT && op == MG_CMD)
			cmd <= alias_op(cmd, OP_WRITE, wb_dat_i, lane_mask, CMD_MASK);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			read_go <= 1'b0;
		else
			read_go <= wr && blk == BLK_MGMT && op == MG_CMD
				&& wb_dat_i[CMD_GO] && lane_mask[CMD_GO];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buf_bytes_o <= '0;
			rx_buf_ok_o <= 1'b0;
		end else begin
			rx_buf_bytes_o <= {rbc[RXBUF_LSB +: RXBUF_W], 4'h0};
			rx_buf_ok_o <= rbc[RXBUF_LSB +: RXBUF_W] != '0;
		end
	end

	always_comb begin
		next_cfg.duplex_select = mfc[MFC_DUPLEX];
		next_cfg.length_field_check = mfc[MFC_LENCK];
		next_cfg.oversize_frame_allow = mfc[MFC_HUGE];
		next_cfg.crc_skip_header = mfc[MFC_DLYCRC];
		// padding always appends, covering software that forgot the crc bit
		next_cfg.fcs_append = mfc[MFC_CRC] | mfc[MFC_PAD];
		next_cfg.crc_check = ~next_cfg.fcs_append;
		if (!mfc[MFC_PAD]) begin
			next_cfg.pad_untagged = PAD_NONE;
			next_cfg.pad_tagged = PAD_NONE;
		end else if (mfc[MFC_VLAN]) begin
			next_cfg.pad_untagged = PAD_TAGGED;
			next_cfg.pad_tagged = PAD_TAGGED;
		end else if (mfc[MFC_AUTO]) begin
			next_cfg.pad_untagged = PAD_PLAIN;
			next_cfg.pad_tagged = PAD_TAGGED;
		end else begin
			next_cfg.pad_untagged = PAD_PLAIN;
			next_cfg.pad_tagged = PAD_PLAIN;
		end
	end

	// a frame in flight keeps the options it started with
	always_ff @(posedge clk_i) begin
		if (rst_i)
			frame_cfg_o <= '0;
		else if (frame_idle_i)
			frame_cfg_o <= next_cfg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			len_mismatch_o <= 1'b0;
			oversize_o <= 1'b0;
		end else begin
			len_mismatch_o <= len_valid_i && frame_cfg_o.length_field_check
				&& len_type_i <= MAX_LEN_FIELD
				&& payload_len_i != len_type_i;
			oversize_o <= len_valid_i && !frame_cfg_o.oversize_frame_allow
				&& frame_len_i > MAX_FRAME;
		end
	end

	assign mreset = rst_i | smc[SMC_RST];
	assign half = MDC_DIV[smc[SMC_CLK_LSB +: 4]] >> 1;
	// >= so a smaller divisor written mid-count cannot overrun
	assign tick = divcnt >= half - 6'h01;
	assign fall = tick & mdc_o;
	assign rise = tick & ~mdc_o;

	always_ff @(posedge clk_i) begin
		if (mreset) begin
			divcnt <= '0;
			mdc_o <= 1'b0;
		end else if (tick) begin
			divcnt <= '0;
			mdc_o <= ~mdc_o;
		end else begin
			divcnt <= divcnt + 6'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mdio_s1 <= 1'b1;
			mdio_s2 <= 1'b1;
		end else begin
			mdio_s1 <= mdio_i;
			mdio_s2 <= mdio_s1;
		end
	end

	assign target_phy_number = cmd[CMD_PHY_LSB +: 5];
	assign reg_number = cmd[CMD_REG_LSB +: 5];
	assign start = mstate == M_IDLE && fall && (pending || cmd[CMD_RUN]);
	assign frame_bits = {START_READ, cur_phy, reg_number, 2'b11, 16'hFFFF};
	assign out_bit = (bitcnt > BIT_FRAME_TOP) ? 1'b1 : frame_bits[bitcnt[4:0]];
	assign status = {7'h00, mstate != M_IDLE || pending, 3'h0,
		last_phy, last_data};

	always_ff @(posedge clk_i) begin
		if (mreset)
			pending <= 1'b0;
		else if (read_go)
			pending <= 1'b1;
		else if (start)
			pending <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (mreset) begin
			mstate <= M_IDLE;
			bitcnt <= '0;
		end else begin
			case (mstate)
				M_IDLE: begin
					if (start) begin
						mstate <= M_SHIFT;
						bitcnt <= smc[SMC_SKIP_PRE] ? BIT_FRAME_TOP
							: BIT_PRE_TOP;
					end
				end
				M_SHIFT: begin
					if (fall) begin
						if (bitcnt == BIT_LAST)
							mstate <= M_GAP;
						else
							bitcnt <= bitcnt - 6'h01;
					end
				end
				M_GAP: begin
					if (fall)
						mstate <= M_IDLE;
				end
				default: mstate <= M_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (mreset)
			rdata <= '0;
		else if (mstate == M_SHIFT && rise && bitcnt <= BIT_DATA_TOP)
			rdata <= {rdata[14:0], mdio_s2};
	end

	always_ff @(posedge clk_i) begin
		if (mreset) begin
			cur_phy <= PHY_FIRST;
			last_phy <= '0;
			last_data <= '0;
		end else if (start && !smc[SMC_SCAN]) begin
			cur_phy <= target_phy_number;
		end else if (mstate == M_GAP && fall) begin
			last_data <= rdata;
			last_phy <= cur_phy;
			if (smc[SMC_SCAN])
				cur_phy <= (cur_phy >= target_phy_number) ? PHY_FIRST
					: cur_phy + 5'h01;
		end
	end

	// pin released outside a frame and during turnaround and data
	always_ff @(posedge clk_i) begin
		if (mreset) begin
			mdio_o <= 1'b1;
			mdio_oe_n_o <= 1'b1;
		end else begin
			mdio_o <= (mstate == M_SHIFT) ? out_bit : 1'b1;
			mdio_oe_n_o <= !(mstate == M_SHIFT && bitcnt >= BIT_DRIVE_LOW);
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_rxbuf_scaled: assert property (
		(wr && blk == BLK_RBC && op == OP_WRITE && wb_sel_i == SEL_WORD)
		|=> ##1 rx_buf_bytes_o == {$past(wb_dat_i[RXBUF_LSB +: RXBUF_W], 2),
		4'h0}) else $error("rx buffer bytes not sixteen times field");
	a_rxbuf_zero: assert property (
		rx_buf_ok_o == (rx_buf_bytes_o != '0))
		else $error("rx buffer valid flag wrong");
	a_byte_ignored: assert property (
		(req && wb_we_i && !lanes_ok) |=> ($stable(rbc) && $stable(mfc)
		&& $stable(smc) && $stable(cmd)))
		else $error("byte write changed a register");
	a_cfg_hold: assert property (
		!frame_idle_i |=> $stable(frame_cfg_o))
		else $error("frame options changed inside a frame");
	a_pad_off: assert property (
		(frame_idle_i && !mfc[MFC_PAD]) |=> (frame_cfg_o.pad_tagged ==
		PAD_NONE && frame_cfg_o.pad_untagged == PAD_NONE
		&& frame_cfg_o.crc_check == !$past(mfc[MFC_CRC])))
		else $error("padding active while disabled");
	a_pad_vlan: assert property (
		(frame_idle_i && mfc[MFC_PAD] && mfc[MFC_VLAN]) |=>
		(frame_cfg_o.pad_untagged == PAD_TAGGED && frame_cfg_o.fcs_append))
		else $error("vlan padding not 64 bytes");
	a_pad_auto: assert property (
		(frame_idle_i && mfc[MFC_PAD] && !mfc[MFC_VLAN] && mfc[MFC_AUTO])
		|=> (frame_cfg_o.pad_untagged == PAD_PLAIN
		&& frame_cfg_o.pad_tagged == PAD_TAGGED))
		else $error("auto padding lengths wrong");
	a_len_flag: assert property (
		(len_valid_i && frame_cfg_o.length_field_check
		&& len_type_i <= MAX_LEN_FIELD && payload_len_i != len_type_i)
		|=> len_mismatch_o) else $error("length mismatch not flagged");
	a_soft_reset: assert property (
		smc[SMC_RST] |=> (mstate == M_IDLE && !mdc_o && mdio_oe_n_o))
		else $error("management engine runs in soft reset");
	a_preamble_len: assert property (
		start |=> bitcnt == ($past(smc[SMC_SKIP_PRE]) ? BIT_FRAME_TOP
		: BIT_PRE_TOP)) else $error("preamble length wrong");
	a_scan_wrap: assert property (
		(mstate == M_GAP && fall && smc[SMC_SCAN]
		&& cur_phy >= target_phy_number) |=> cur_phy == PHY_FIRST)
		else $error("scan did not wrap to first phy");
	a_mdc_period: assert property (
		($changed(mdc_o) && !$past(smc[SMC_RST])) |->
		$past(divcnt) >= $past(half) - 6'h01)
		else $error("management clock toggled early");
	a_mdc_divider_code_por: assert property (
		$past(rst_i) |-> smc == SMC_RESET)
		else $error("management config reset value wrong");
endmodule : mac_frame_mgmt_cfg

/* include/mac_cfg_pkg.sv */
// constants, types and register map for the mac configuration block
package mac_cfg_pkg;
	// register blocks, picked by byte address bits 7:4
	localparam logic [3:0] BLK_RBC = 4'h0;
	localparam logic [3:0] BLK_MFC = 4'h1;
	localparam logic [3:0] BLK_SMC = 4'h2;
	localparam logic [3:0] BLK_MGMT = 4'h3;
	// alias, picked by byte address bits 3:2
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_CLR = 2'h1;
	localparam logic [1:0] OP_SET = 2'h2;
	localparam logic [1:0] OP_INV = 2'h3;
	// inside the management block, then the accepted byte lane patterns
	localparam logic [1:0] MG_CMD = 2'h0;
	localparam logic [1:0] MG_STAT = 2'h1;
	localparam logic [3:0] SEL_WORD = 4'hF;
	localparam logic [3:0] SEL_LOW = 4'h3;
	localparam logic [3:0] SEL_HIGH = 4'hC;
	// rx_buffer_size_control
	localparam int RXBUF_LSB = 4;
	localparam int RXBUF_W = 7;
	localparam logic [31:0] RBC_MASK = 32'h0000_07F0;
	localparam logic [31:0] RBC_RESET = 32'h0000_0000;
	// mac_frame_config
	localparam int MFC_DUPLEX = 0;
	localparam int MFC_LENCK = 1;
	localparam int MFC_HUGE = 2;
	localparam int MFC_DLYCRC = 3;
	localparam int MFC_CRC = 4;
	localparam int MFC_PAD = 5;
	localparam int MFC_VLAN = 6;
	localparam int MFC_AUTO = 7;
	localparam logic [31:0] MFC_MASK = 32'h0000_00FF;
	localparam logic [31:0] MFC_RESET = 32'h0000_0000;
	// station_mgmt_config
	localparam int SMC_SCAN = 0;
	localparam int SMC_SKIP_PRE = 1;
	localparam int SMC_CLK_LSB = 2;
	localparam int SMC_RST = 15;
	localparam logic [31:0] SMC_MASK = 32'h0000_803F;
	localparam logic [31:0] SMC_RESET = 32'h0000_0020;
	// management command and status
	localparam int CMD_REG_LSB = 0;
	localparam int CMD_PHY_LSB = 8;
	localparam int CMD_GO = 16;
	localparam int CMD_RUN = 17;
	localparam logic [31:0] CMD_MASK = 32'h0002_1F1F;
	localparam int STAT_PHY_LSB = 16;
	localparam int STAT_BUSY = 24;
	// padding and length limits in bytes
	localparam logic [6:0] PAD_NONE = 7'h00;
	localparam logic [6:0] PAD_PLAIN = 7'h3C;
	localparam logic [6:0] PAD_TAGGED = 7'h40;
	localparam logic [15:0] MAX_LEN_FIELD = 16'h05DC;
	localparam logic [15:0] MAX_FRAME = 16'h05EE;
	// management clock division per divider code
	localparam logic [5:0] MDC_DIV [16] = '{
		6'h04, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0E, 6'h14, 6'h1C,
		6'h28, 6'h30, 6'h32, 6'h28, 6'h28, 6'h28, 6'h28, 6'h28};
	// management frame: bit counter tops and field bounds
	localparam logic [5:0] BIT_PRE_TOP = 6'h3F;
	localparam logic [5:0] BIT_FRAME_TOP = 6'h1F;
	localparam logic [5:0] BIT_DRIVE_LOW = 6'h12;
	localparam logic [5:0] BIT_DATA_TOP = 6'h0F;
	localparam logic [5:0] BIT_LAST = 6'h00;
	localparam logic [3:0] START_READ = 4'h6;
	localparam logic [4:0] PHY_FIRST = 5'h01;

	typedef struct packed {
		logic [6:0] pad_untagged;
		logic [6:0] pad_tagged;
		logic fcs_append;
		logic crc_check;
		logic crc_skip_header;
		logic oversize_frame_allow;
		logic length_field_check;
		logic duplex_select;
	} frame_cfg_t;

	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_SHIFT = 2'b01,
		M_GAP = 2'b11
	} mgmt_state_t;
endpackage : mac_cfg_pkg

/* tb/phy_mgmt_model.sv */
// phy end of the station management link, answering every read
`timescale 1ns/1ps
module phy_mgmt_model (
	input wire logic mdc_i,
	input wire logic drive_i,
	input wire logic drive_oe_n_i,
	output logic line_o,
	output logic [4:0] last_phy_o,
	output int last_bits_o,
	output int frames_o
);
	logic [9:0] sh = 10'h000;
	logic [15:0] resp;
	int nbits = 0;
	// large start keeps the phy quiet until a first frame
	int rc = 99;
	initial begin
		last_phy_o = 5'h00;
		last_bits_o = 0;
		frames_o = 0;
	end
	// answer carries the phy and register numbers it was asked for
	assign resp = {sh, 6'h15};
	// released line floats to the pull-up level
	assign line_o = !drive_oe_n_i ? drive_i : (rc == 1) ? 1'b0 :
		(rc > 1 && rc < 18) ? resp[17 - rc] : 1'b1;
	always @(posedge mdc_i or posedge drive_oe_n_i) begin
		if (drive_oe_n_i) begin
			if (nbits != 0) begin
				last_bits_o = nbits;
				last_phy_o = sh[9:5];
				frames_o++;
			end
			nbits = 0;
		end else begin
			nbits++;
			sh = {sh[8:0], drive_i};
		end
	end
	// phy changes its bits on the falling management clock edge
	always @(negedge mdc_i) begin
		if (!drive_oe_n_i)
			rc = 0;
		else if (rc < 99)
			rc++;
	end
endmodule : phy_mgmt_model

/* tb/test_mac_frame_mgmt_cfg.sv */
// bench for the mac frame options and station management block
`timescale 1ns/1ps
module test_mac_frame_mgmt_cfg;
	import mac_cfg_pkg::*;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc = 0;
	logic we = 0;
	logic idle = 1;
	logic lv = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rd;
	logic [31:0] seed = 32'h0000_001D;
	logic [15:0] flen = 16'h0000;
	logic [15:0] plen = 16'h0000;
	logic [15:0] ltype = 16'h0000;
	logic [31:0] wb_dat_o;
	logic [10:0] rx_buf_bytes_o;
	logic wb_ack_o, rx_buf_ok_o, len_mismatch_o, oversize_o;
	logic mdc_o, mdio_o, mdio_oe_n_o, mdio_line;
	logic [4:0] last_phy;
	frame_cfg_t frame_cfg_o;
	int last_bits, frames;
	int failures = 0;
	int n_checks = 0;
	int divs[11] = '{4, 4, 6, 8, 10, 14, 20, 28, 40, 48, 50};
	logic [32:0] notes[$];
	logic [1:0] flag_notes[$];
	logic lv_seen = 0;

	mac_frame_mgmt_cfg mac_frame_mgmt_cfg_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .frame_idle_i(idle), .len_valid_i(lv),
		.frame_len_i(flen), .payload_len_i(plen), .len_type_i(ltype),
		.frame_cfg_o(frame_cfg_o), .rx_buf_bytes_o(rx_buf_bytes_o),
		.rx_buf_ok_o(rx_buf_ok_o), .len_mismatch_o(len_mismatch_o),
		.oversize_o(oversize_o), .mdc_o(mdc_o), .mdio_i(mdio_line),
		.mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o));
	phy_mgmt_model phy_mgmt_model_inst (.mdc_i(mdc_o), .drive_i(mdio_o),
		.drive_oe_n_i(mdio_oe_n_o), .line_o(mdio_line),
		.last_phy_o(last_phy), .last_bits_o(last_bits), .frames_o(frames));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task automatic judge(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask : judge

	// one compare task per kind of result
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		judge(got, exp);
	endtask : cmp_reg

	task automatic cmp_cfg(input logic [31:0] got, input logic [31:0] exp);
		judge(got, exp);
	endtask : cmp_cfg

	task automatic cmp_len(input logic [31:0] got, input logic [31:0] exp);
		judge(got, exp);
	endtask : cmp_len

	task automatic cmp_link(input logic [31:0] got, input logic [31:0] exp);
		judge(got, exp);
	endtask : cmp_link

	task automatic close_out();
		if (failures == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// reads note their expectation; c low marks a read kept unchecked
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d, input logic c);
		cyc <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		if (!w)
			notes.push_back({c, d});
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		bus(1, a, s, d, 0);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 4'hF, e, 1);
	endtask : rdc

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !we && notes.size() > 0) begin
			if (notes[0][32])
				cmp_reg(wb_dat_o, notes[0][31:0]);
			void'(notes.pop_front());
		end
	end

	// flags answer one cycle after the length strobe
	always @(posedge clk_i) begin
		lv_seen <= lv;
		if (lv_seen && flag_notes.size() > 0)
			cmp_len({30'h0, len_mismatch_o, oversize_o},
				{30'h0, flag_notes.pop_front()});
	end

	task automatic len(input logic [15:0] f, p, t, input logic m, o);
		flen <= f;
		plen <= p;
		ltype <= t;
		lv <= 1;
		flag_notes.push_back({m, o});
		@(posedge clk_i);
		lv <= 0;
		@(posedge clk_i);
	endtask : len

	task automatic wait_mdc(input logic v, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (mdc_o !== v && n < 200);
	endtask : wait_mdc

	task automatic period(input int d);
		int a, b;
		wait_mdc(1, a);
		wait_mdc(0, a);
		wait_mdc(1, a);
		wait_mdc(0, a);
		wait_mdc(1, b);
		cmp_link(a + b, d);
	endtask : period

	task automatic wait_done();
		for (int t = 0; t < 300; t++) begin
			bus(0, 8'h34, 4'hF, 32'h0, 0);
			if (rd[24] === 1'b0)
				break;
		end
	endtask : wait_done

	task automatic next_frame();
		int n, t;
		n = frames;
		t = 0;
		while (frames == n && t < 2000) begin
			@(posedge clk_i);
			t++;
		end
	endtask : next_frame

	initial begin
		repeat (40000) @(posedge clk_i);
		failures++;
		close_out();
	end

	initial begin
		logic [6:0] f, pu, pt;
		logic [7:0] m;
		logic [31:0] r, e;
		logic fa, hi;
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		rdc(8'h20, 32'h0000_0020);
		rdc(8'h00, 32'h0000_0000);
		cmp_cfg({20'h0, rx_buf_bytes_o, rx_buf_ok_o},
			32'h0000_0000);
		period(40);
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			f = (i == 0) ? 7'h7F : (i == 1) ? 7'h01 : r[6:0];
			// zero is reserved, so software never writes it
			if (f == 7'h00)
				f = 7'h60;
			wr(8'h00, 4'hF, {21'h0, f, 4'hF}); // receiver stays off
			rdc(8'h00, {21'h0, f, 4'h0});
			cmp_cfg({20'h0, rx_buf_bytes_o, rx_buf_ok_o},
				{20'h0, f, 4'h0, f != 7'h00});
		end
		wr(8'h10, 4'hF, 32'h0000_00B5);
		wr(8'h10, 4'h1, 32'h0000_005A);
		wr(8'h18, 4'h3, 32'h0000_0002);
		wr(8'h14, 4'hC, 32'hFFFF_FFFF);
		wr(8'h1C, 4'hF, 32'h0000_0081);
		rdc(8'h1C, 32'h0000_0036);
		bus(0, 8'h10, 4'h1, 32'h0, 1);
		rdc(8'h40, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			// crc option follows padding, as software must
			m = {i[3:0], i[3:0]} | {3'h0, i[1], 4'h0};
			wr(8'h10, 4'hF, {24'h0, m});
			pu = m[5] ? (m[6] ? 7'h40 : 7'h3C) : 7'h00;
			pt = m[5] ? ((m[6] | m[7]) ? 7'h40 : 7'h3C) : 7'h00;
			fa = m[4] | m[5];
			e = {12'h0, pu, pt, fa, !fa, m[3:0]};
			cmp_cfg({12'h0, frame_cfg_o},
				e);
		end
		idle <= 0;
		wr(8'h10, 4'hF, 32'h0000_0000);
		cmp_cfg({12'h0, frame_cfg_o}, e);
		idle <= 1;
		repeat (2) @(posedge clk_i);
		cmp_cfg({12'h0, frame_cfg_o}, 32'h0000_0010);
		len(16'h05EF, 16'h000A, 16'h000A, 0, 1);
		len(16'h05EE, 16'h0063, 16'h0064, 0, 0);
		wr(8'h10, 4'hF, 32'h0000_0006);
		len(16'h05EF, 16'h0063, 16'h0064, 1, 0);
		len(16'h0064, 16'h0064, 16'h0064, 0, 0);
		len(16'h0064, 16'h0063, 16'h0800, 0, 0);
		for (int c = 0; c < 11; c++) begin
			wr(8'h20, 4'hF, c << 2);
			period(divs[c]);
		end
		// codes past the table fall back to the reset divisor
		wr(8'h20, 4'hF, 32'h0000_003C);
		period(40);
		// divide by 6 gives about 3.3 MHz, within the phy limit
		wr(8'h20, 4'hF, 32'h0000_0008);
		wr(8'h30, 4'hF, 32'h0001_0503);
		wait_done();
		rdc(8'h34, {11'h0, 5'h05, 5'h05, 5'h03, 6'h15});
		cmp_link(last_bits, 46);
		wr(8'h20, 4'hF, 32'h0000_000A);
		wr(8'h30, 4'hF, 32'h0001_0503);
		wait_done();
		cmp_link(last_bits, 14);
		wr(8'h28, 4'hF, 32'h0000_8000);
		rdc(8'h20, 32'h0000_800A);
		hi = 0;
		repeat (60) @(posedge clk_i) hi |= mdc_o;
		cmp_link({31'h0, hi}, 32'h0000_0000);
		wr(8'h24, 4'hF, 32'h0000_8002);
		wr(8'h20, 4'hF, 32'h0000_0009);
		wr(8'h30, 4'hF, 32'h0002_0300);
		for (int k = 0; k < 4; k++) begin
			next_frame();
			cmp_link({27'h0, last_phy}, (k % 3) + 1);
		end
		wr(8'h30, 4'hF, 32'h0000_0000);
		close_out();
	end
endmodule : test_mac_frame_mgmt_cfg
